// ===== camds_datapath.sv
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
// Summary of operation
// - Data space linear: 32K words, 64K bytes
// - Upper 32K bytes map to program page
// - Single-cycle 17x17 multiplier, mixed-sign capable
// - Multiply modes: ss, uu, us, literal, 8x8
// - Signed/unsigned 32/16 and 16/16 divide
// - Divide interruptible, partial state kept intact
// - One iteration per divisor bit, equal timing
// - Quotient to register 0, remainder register 1
// - Any divisor register; even-aligned dividend pair
// - One-cycle shift up to 16, register/memory
// - Signed count: positive right, negative left
// - 16-bit ALU: add, sub, shift, logic
// - Byte or word operation by size mode
// - First operand and ALU/shift results: registers or memory
// - Add/sub update C, Z, N, OV, DC; logic and shift update only N, Z
// - Subtract: C, DC are inverted borrows
// - Priority level is top bit plus status[7:5]
// - Top bit set by hardware, only clearable
// - Control bit 2 enables program window
// - Unimplemented status/control bits read zero
module camds_datapath #(
    parameter int unsigned ADDR_W = camds_pkg::CAMDS_ADDR_W
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Register bus
    input wire camds_pkg::camds_avs_req_type avs_req_i,
    output camds_pkg::camds_avs_rsp_type avs_rsp_o,
    // Priority raise from interrupt logic on the same clock
    input wire logic priority_raise_i,
    // Address mapping and priority
    output logic [3:0] cpu_priority_o,
    output logic program_window_hit_o,
    output logic [22:0] program_addr_o,
    output logic [14:0] data_word_addr_o
);
    import camds_pkg::*;

    // ==========================================================
    // Parameter check
    // ==========================================================
    generate
        if (ADDR_W != CAMDS_ADDR_W) begin : g_bad_addr
            $error("ADDR_W must match the map");
        end
    endgenerate

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic [15:0][15:0] wreg;
        logic [15:0] status;
        logic prio_top;
        logic program_window_enable;
        logic [7:0] page;
        logic [15:0] mem_operand;
        logic [15:0] mem_result;
        logic [15:0] ea;
        logic [15:0] rem;
        logic [15:0] quo;
        logic [15:0] dvs;
        logic [4:0] dstep;
        logic neg_q;
        logic neg_r;
        logic dovf;
        logic [3:0] prio;
        logic hit;
        logic [22:0] paddr;
        logic [14:0] dword;
    } camds_state_type;

    camds_state_type s;
    camds_state_type next_s;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic access;
        camds_cmd_type cmd;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] bb;
        logic cin;
        logic [16:0] sum16;
        logic [8:0] sum8;
        logic [4:0] sum4;
        logic [15:0] res;
        logic res_valid;
        logic [4:0] mag;
        logic [15:0] bneg;
        logic [16:0] mx;
        logic [16:0] my;
        logic [33:0] prod;
        logic [31:0] dd;
        logic [31:0] ddm;
        logic [15:0] dvm;
        logic nd;
        logic nv;
        logic [16:0] trial;
        logic ge;
        logic [15:0] wr_old;
        access = 1'b0;
        cmd = '1; // Spare op code: idle cycles run nothing
        a = '0;
        b = '0;
        bb = '0;
        cin = 1'b0;
        sum16 = '0;
        sum8 = '0;
        sum4 = '0;
        res = '0;
        res_valid = 1'b0;
        mag = '0;
        bneg = '0;
        mx = '0;
        my = '0;
        prod = '0;
        dd = '0;
        ddm = '0;
        dvm = '0;
        nd = 1'b0;
        nv = 1'b0;
        trial = '0;
        ge = 1'b0;
        wr_old = '0;
        next_s = s;
        next_s.waitreq = 1'b1;
        // Ack cycle holds waitrequest low; the held request is not redone
        access = (avs_req_i.read | avs_req_i.write) & s.waitreq;
        if (access) begin
            next_s.waitreq = 1'b0;
            next_s.rdata = '0;
        end
        if (access && avs_req_i.read) begin
            if (avs_req_i.address[7:6] == CAMDS_WREG_PAGE) begin
                next_s.rdata[15:0] = s.wreg[avs_req_i.address[5:2]];
            end else begin
                unique case (avs_req_i.address)
                    CAMDS_OFF_STATUS: next_s.rdata[15:0] = s.status;
                    CAMDS_OFF_CONTROL: begin
                        next_s.rdata[CAMDS_CC_TOP] = s.prio_top;
                        next_s.rdata[CAMDS_CC_PSV] = s.program_window_enable;
                    end
                    CAMDS_OFF_PAGE: next_s.rdata[7:0] = s.page;
                    CAMDS_OFF_MEM_OPERAND: next_s.rdata[15:0] = s.mem_operand;
                    CAMDS_OFF_MEM_RESULT: next_s.rdata[15:0] = s.mem_result;
                    CAMDS_OFF_EA: next_s.rdata[15:0] = s.ea;
                    CAMDS_OFF_MAPPED: begin
                        next_s.rdata[23] = s.hit;
                        next_s.rdata[22:0] = s.paddr;
                    end
                    default: next_s.rdata = '0;
                endcase
            end
        end
        if (access && avs_req_i.write) begin
            if (avs_req_i.address[7:6] == CAMDS_WREG_PAGE) begin
                next_s.wreg[avs_req_i.address[5:2]] = merge16(
                    s.wreg[avs_req_i.address[5:2]], avs_req_i.writedata,
                    avs_req_i.byteenable);
            end else begin
                unique case (avs_req_i.address)
                    CAMDS_OFF_STATUS: begin
                        next_s.status = (merge16(s.status,
                            avs_req_i.writedata, avs_req_i.byteenable)
                            & CAMDS_SR_WMASK)
                            | (s.status & ~CAMDS_SR_WMASK);
                    end
                    CAMDS_OFF_CONTROL: begin
                        if (avs_req_i.byteenable[0]) begin
                            next_s.program_window_enable =
                                avs_req_i.writedata[CAMDS_CC_PSV];
                            next_s.prio_top = s.prio_top
                                & avs_req_i.writedata[CAMDS_CC_TOP];
                        end
                    end
                    CAMDS_OFF_PAGE: begin
                        if (avs_req_i.byteenable[0]) begin
                            next_s.page = avs_req_i.writedata[7:0];
                        end
                    end
                    CAMDS_OFF_MEM_OPERAND: begin
                        next_s.mem_operand = merge16(s.mem_operand,
                            avs_req_i.writedata, avs_req_i.byteenable);
                    end
                    CAMDS_OFF_EA: begin
                        next_s.ea = merge16(s.ea, avs_req_i.writedata,
                            avs_req_i.byteenable);
                    end
                    CAMDS_OFF_COMMAND: begin
                        if (&avs_req_i.byteenable) begin
                            cmd = camds_cmd_type'(avs_req_i.writedata);
                        end
                    end
                    default: next_s.rdata = '0;
                endcase
            end
        end

        // ======================================================
        // Command execution, one command per bus write
        // ======================================================
        a = cmd.src_mem ? s.mem_operand : s.wreg[cmd.ra];
        b = s.wreg[cmd.rb];
        cin = (cmd.op == CAMDS_OP_SUB);
        bb = cin ? ~b : b;
        // Subtract as a + ~b + 1 leaves carries as inverted borrows
        sum16 = {1'b0, a} + {1'b0, bb} + {16'h0000, cin};
        sum8 = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, cin};
        sum4 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        bneg = -b;
        unique case (cmd.op)
            CAMDS_OP_ADD, CAMDS_OP_SUB: begin
                res_valid = 1'b1;
                if (cmd.byte_mode) begin
                    res = {8'h00, sum8[7:0]};
                    next_s.status[CAMDS_SR_C] = sum8[8];
                    next_s.status[CAMDS_SR_DC] = sum4[4];
                    next_s.status[CAMDS_SR_OV] = (a[7] == bb[7])
                        && (sum8[7] != a[7]);
                    next_s.status[CAMDS_SR_N] = sum8[7];
                    next_s.status[CAMDS_SR_Z] = (sum8[7:0] == 8'h00);
                end else begin
                    res = sum16[15:0];
                    next_s.status[CAMDS_SR_C] = sum16[16];
                    next_s.status[CAMDS_SR_DC] = sum8[8];
                    next_s.status[CAMDS_SR_OV] = (a[15] == bb[15])
                        && (sum16[15] != a[15]);
                    next_s.status[CAMDS_SR_N] = sum16[15];
                    next_s.status[CAMDS_SR_Z] = (sum16[15:0] == 16'h0000);
                end
            end
            CAMDS_OP_AND, CAMDS_OP_IOR, CAMDS_OP_XOR: begin
                res_valid = 1'b1;
                res = (cmd.op == CAMDS_OP_AND) ? (a & b) :
                      (cmd.op == CAMDS_OP_IOR) ? (a | b) : (a ^ b);
                if (cmd.byte_mode) begin
                    res[15:8] = 8'h00;
                    next_s.status[CAMDS_SR_N] = res[7];
                    next_s.status[CAMDS_SR_Z] = (res[7:0] == 8'h00);
                end else begin
                    next_s.status[CAMDS_SR_N] = res[15];
                    next_s.status[CAMDS_SR_Z] = (res == 16'h0000);
                end
            end
            CAMDS_OP_SHA, CAMDS_OP_SHL: begin
                res_valid = 1'b1;
                // Magnitudes above 16 clamp to a full shift-out
                mag = b[15] ? ((bneg > 16'h0010) ? CAMDS_SHIFT_MAX
                                                 : bneg[4:0])
                            : ((b > 16'h0010) ? CAMDS_SHIFT_MAX : b[4:0]);
                if (b[15]) begin
                    res = a << mag;
                end else if (cmd.op == CAMDS_OP_SHA) begin
                    res = 16'($signed(a) >>> mag);
                end else begin
                    res = a >> mag;
                end
                next_s.status[CAMDS_SR_N] = res[15];
                next_s.status[CAMDS_SR_Z] = (res == 16'h0000);
            end
            CAMDS_OP_MUL: begin
                unique case (camds_mul_type'(cmd.mode))
                    CAMDS_MUL_SS: {mx, my} = {a[15], a, b[15], b};
                    CAMDS_MUL_UU: {mx, my} = {1'b0, a, 1'b0, b};
                    CAMDS_MUL_US: {mx, my} = {1'b0, a, b[15], b};
                    CAMDS_MUL_SLIT: {mx, my} = {a[15], a, 12'h0, cmd.literal};
                    CAMDS_MUL_ULIT: {mx, my} = {1'b0, a, 12'h0, cmd.literal};
                    CAMDS_MUL_BYTE: {mx, my} = {9'h0, a[7:0], 9'h0, b[7:0]};
                    default: mx = '0;
                endcase
                // Extension to 17 bits makes one signed array serve all
                prod = 34'($signed(mx) * $signed(my));
                next_s.wreg[{cmd.rd[3:1], 1'b0}] = prod[15:0];
                next_s.wreg[{cmd.rd[3:1], 1'b1}] = prod[31:16];
            end
            CAMDS_OP_DIV: begin
                // Private registers keep a paused divide safe from others
                if (s.dstep == 5'h00) begin
                    dd = cmd.mode[1] ? {s.wreg[{cmd.ra[3:1], 1'b1}],
                                        s.wreg[{cmd.ra[3:1], 1'b0}]}
                       : cmd.mode[0] ? {{16{s.wreg[cmd.ra][15]}},
                                        s.wreg[cmd.ra]}
                       : {16'h0000, s.wreg[cmd.ra]};
                    nd = cmd.mode[0] & dd[31];
                    nv = cmd.mode[0] & b[15];
                    ddm = nd ? -dd : dd;
                    dvm = nv ? bneg : b;
                    next_s.rem = ddm[31:16];
                    next_s.quo = ddm[15:0];
                    next_s.dvs = dvm;
                    next_s.neg_q = nd ^ nv;
                    next_s.neg_r = nd;
                    next_s.dovf = (ddm[31:16] >= dvm);
                    next_s.dstep = 5'h01;
                    next_s.status[CAMDS_SR_RA] = 1'b1;
                end else if (s.dstep <= CAMDS_DIV_BITS) begin
                    trial = {s.rem, s.quo[15]};
                    ge = (trial >= {1'b0, s.dvs});
                    next_s.rem = ge ? 16'(trial - {1'b0, s.dvs})
                                    : trial[15:0];
                    next_s.quo = {s.quo[14:0], ge};
                    next_s.dstep = 5'(s.dstep + 5'h01);
                end else begin
                    next_s.wreg[0] = s.neg_q ? -s.quo : s.quo;
                    next_s.wreg[1] = s.neg_r ? -s.rem : s.rem;
                    next_s.status[CAMDS_SR_OV] = s.dovf;
                    next_s.status[CAMDS_SR_Z] = (s.quo == 16'h0000);
                    next_s.status[CAMDS_SR_N] = s.neg_q
                        & (s.quo != 16'h0000);
                    next_s.status[CAMDS_SR_RA] = 1'b0;
                    next_s.dstep = 5'h00;
                end
            end
            default: res_valid = 1'b0;
        endcase
        if (res_valid) begin
            wr_old = cmd.dst_mem ? s.mem_result : s.wreg[cmd.rd];
            if (cmd.byte_mode) begin
                res = {wr_old[15:8], res[7:0]};
            end
            if (cmd.dst_mem) begin
                next_s.mem_result = res;
            end else begin
                next_s.wreg[cmd.rd] = res;
            end
        end

        // ======================================================
        // Priority and address mapping
        // ======================================================
        // Hardware raise applies after the software clear, so it wins
        if (priority_raise_i) begin
            next_s.prio_top = 1'b1;
        end
        next_s.prio = {next_s.prio_top,
                       next_s.status[CAMDS_SR_IPL +: 3]};
        next_s.dword = next_s.ea[15:1];
        next_s.hit = next_s.program_window_enable & next_s.ea[15];
        next_s.paddr = {next_s.page, next_s.ea[14:0]};
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            s <= '0;
            s.waitreq <= 1'b1;
            s.status <= CAMDS_STATUS_RST;
            s.program_window_enable <= CAMDS_PSV_RST;
            s.prio_top <= CAMDS_TOP_RST;
            s.page <= CAMDS_PAGE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign avs_rsp_o.waitrequest = s.waitreq;
    assign avs_rsp_o.readdata = s.rdata;
    assign cpu_priority_o = s.prio;
    assign program_window_hit_o = s.hit;
    assign program_addr_o = s.paddr;
    assign data_word_addr_o = s.dword;

endmodule : camds_datapath

// ===== camds_pkg.sv
package camds_pkg;

    // ==========================================================
    // Bus and register map
    // ==========================================================
    localparam int unsigned CAMDS_ADDR_W = 8;
    localparam logic [7:0] CAMDS_OFF_STATUS = 8'h00;
    localparam logic [7:0] CAMDS_OFF_CONTROL = 8'h04;
    localparam logic [7:0] CAMDS_OFF_PAGE = 8'h08;
    localparam logic [7:0] CAMDS_OFF_COMMAND = 8'h0c;
    localparam logic [7:0] CAMDS_OFF_MEM_OPERAND = 8'h10;
    localparam logic [7:0] CAMDS_OFF_MEM_RESULT = 8'h14;
    localparam logic [7:0] CAMDS_OFF_EA = 8'h18;
    localparam logic [7:0] CAMDS_OFF_MAPPED = 8'h1c;
    // Working registers sit at 0x40 + 4*n, n = 0..15
    localparam logic [1:0] CAMDS_WREG_PAGE = 2'h1;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int unsigned CAMDS_SR_C = 0;
    localparam int unsigned CAMDS_SR_Z = 1;
    localparam int unsigned CAMDS_SR_OV = 2;
    localparam int unsigned CAMDS_SR_N = 3;
    localparam int unsigned CAMDS_SR_RA = 4;
    localparam int unsigned CAMDS_SR_IPL = 5;
    localparam int unsigned CAMDS_SR_DC = 8;
    localparam int unsigned CAMDS_CC_PSV = 2;
    localparam int unsigned CAMDS_CC_TOP = 3;
    localparam logic [15:0] CAMDS_SR_WMASK = 16'h01ef;

    // ==========================================================
    // Reset values and timing counts
    // ==========================================================
    localparam logic [15:0] CAMDS_STATUS_RST = 16'h0000;
    localparam logic CAMDS_PSV_RST = 1'b0;
    localparam logic CAMDS_TOP_RST = 1'b0;
    localparam logic [7:0] CAMDS_PAGE_RST = 8'h00;
    localparam logic [4:0] CAMDS_DIV_BITS = 5'h10;
    localparam logic [4:0] CAMDS_DIV_LAST = 5'h11;
    localparam logic [4:0] CAMDS_SHIFT_MAX = 5'h10;

    // ==========================================================
    // Commands
    // ==========================================================
    typedef enum logic [3:0] {
        CAMDS_OP_ADD, CAMDS_OP_SUB, CAMDS_OP_AND, CAMDS_OP_IOR,
        CAMDS_OP_XOR, CAMDS_OP_SHA, CAMDS_OP_SHL, CAMDS_OP_MUL,
        CAMDS_OP_DIV
    } camds_op_type;

    typedef enum logic [2:0] {
        CAMDS_MUL_SS, CAMDS_MUL_UU, CAMDS_MUL_US, CAMDS_MUL_SLIT,
        CAMDS_MUL_ULIT, CAMDS_MUL_BYTE
    } camds_mul_type;

    // Divide mode: bit 0 signed, bit 1 32-bit dividend
    typedef struct packed {
        logic [2:0] spare_hi;
        logic [4:0] literal;
        logic spare_mid;
        logic [2:0] mode;
        logic [3:0] rd;
        logic [3:0] rb;
        logic [3:0] ra;
        logic spare_lo;
        logic dst_mem;
        logic src_mem;
        logic byte_mode;
        camds_op_type op;
    } camds_cmd_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [CAMDS_ADDR_W-1:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } camds_avs_req_type;

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
    } camds_avs_rsp_type;

endpackage : camds_pkg

// ===== camds_datapath_properties.sv
`timescale 1ns/100ps
// ==========
// Port checks
module camds_datapath_props (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire camds_pkg::camds_avs_req_type avs_req_i,
    input wire camds_pkg::camds_avs_rsp_type avs_rsp_o,
    input wire logic priority_raise_i,
    input wire logic [3:0] cpu_priority_o,
    input wire logic program_window_hit_o,
    input wire logic [22:0] program_addr_o,
    input wire logic [14:0] data_word_addr_o
);
    import camds_pkg::*;
    logic waiting;
    logic rd_ack;
    assign waiting = avs_rsp_o.waitrequest;
    assign rd_ack = avs_req_i.read && !waiting;
    default clocking dc @(posedge clock_i); endclocking
    default disable iff (srst_i);
    ack_next_a:
        assert property ((avs_req_i.read || avs_req_i.write) && waiting
            |=> !waiting)
        else $error("no ack");
    ack_single_a:
        assert property (!waiting |=> waiting)
        else $error("long ack");
    raise_top_a:
        assert property (priority_raise_i |-> ##[1:2] cpu_priority_o[3])
        else $error("top not set");
    top_hw_only_a:
        assert property ($rose(cpu_priority_o[3]) |->
            $past(priority_raise_i) || $past(priority_raise_i, 2))
        else $error("top set alone");
    addr_agree_a:
        assert property (program_addr_o[14:1] == data_word_addr_o[13:0])
        else $error("addr mismatch");
    window_upper_a:
        assert property (program_window_hit_o |-> data_word_addr_o[14])
        else $error("hit below");
    status_zero_a:
        assert property (rd_ack && avs_req_i.address == CAMDS_OFF_STATUS
            |-> avs_rsp_o.readdata[31:9] == '0)
        else $error("status unused bits set");
    control_zero_a:
        assert property (rd_ack && avs_req_i.address == CAMDS_OFF_CONTROL
            |-> avs_rsp_o.readdata[31:4] == '0 && avs_rsp_o.readdata[1:0] == '0)
        else $error("control unused bits set");
    cover property (rd_ack);
    cover property (program_window_hit_o);
    cover property ($rose(cpu_priority_o[3]));
endmodule : camds_datapath_props

// ===== camds_datapath_test.sv
`timescale 1ns/100ps
// ==========
// Bench
module camds_datapath_test;
    import camds_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic priority_raise_i = 1'b0;
    camds_avs_req_type avs_req_i = '0;
    camds_avs_rsp_type avs_rsp_o;
    logic [3:0] cpu_priority_o;
    logic program_window_hit_o;
    logic [22:0] program_addr_o;
    logic [14:0] data_word_addr_o;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    camds_datapath uut (.clock_i, .srst_i, .avs_req_i, .avs_rsp_o,
        .priority_raise_i, .cpu_priority_o, .program_window_hit_o,
        .program_addr_o, .data_word_addr_o);
    always #10 clock_i = ~clock_i;
    task automatic complete_run;
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            failures++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        avs_req_i <= {!w, w, a, 4'hf, d};
        @(posedge clock_i);
        while (avs_rsp_o.waitrequest)
            @(posedge clock_i);
        q = avs_rsp_o.readdata;
        avs_req_i <= '0;
        @(posedge clock_i);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : rd
    function automatic logic [7:0] wa(input logic [3:0] n);
        return {CAMDS_WREG_PAGE, n, 2'h0};
    endfunction : wa
    function automatic logic [31:0] cmd(input logic [3:0] op, ra, rb, rd,
            input logic [2:0] md, input logic [4:0] lt);
        return {3'h0, lt, 1'b0, md, rd, rb, ra, 4'h0, op};
    endfunction : cmd
    function automatic logic [31:0] alu(input logic [3:0] op,
            input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        logic [8:0] h;
        logic [15:0] r;
        logic ar;
        ar = op < 2;
        s = {1'b0, a} + {1'b0, op == 1 ? ~b : b} + 17'(op == 1);
        h = {1'b0, a[7:0]} + {1'b0, op == 1 ? ~b[7:0] : b[7:0]} + 9'(op == 1);
        r = op == 2 ? a & b : op == 3 ? a | b : op == 4 ? a ^ b : s[15:0];
        return {7'h0, ar && h[8], 4'h0, r[15],
            ar && a[15] == (b[15] ^ (op == 1)) && r[15] != a[15],
            r == 16'h0, ar && s[16], r};
    endfunction : alu
    function automatic logic [15:0] shf(input logic ar,
            input logic [15:0] a, input logic signed [15:0] c);
        int m;
        m = c < 0 ? -c : c;
        if (m > 16)
            m = 16;
        if (c < 0)
            return a << m;
        if (ar)
            return $signed(a) >>> m;
        return a >> m;
    endfunction : shf
    function automatic logic [31:0] mul(input logic [2:0] m,
            input logic [15:0] a, input logic [15:0] b, input logic [4:0] l);
        logic [31:0] x;
        logic [31:0] y;
        x = (m == 0 || m == 3) ? {{16{a[15]}}, a} : {16'h0, a};
        y = m > 2 ? {27'h0, l} : m != 1 ? {{16{b[15]}}, b} : {16'h0, b};
        if (m == 5) begin
            x = {24'h0, a[7:0]};
            y = {24'h0, b[7:0]};
        end
        return x * y;
    endfunction : mul
    initial begin
        logic [31:0] a, b, q, n, d, p;
        logic [15:0] cnt [6];
        logic [4:0] l;
        logic [3:0] op;
        cnt = '{16'h3, 16'hfffd, 16'h0, 16'h10, 16'hfff0, 16'hffec};
        void'($urandom(83724));
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        rd(CAMDS_OFF_STATUS, 32'h0);
        rd(CAMDS_OFF_CONTROL, 32'h0);
        a = $urandom;
        wr(CAMDS_OFF_STATUS, a);
        rd(CAMDS_OFF_STATUS, {16'h0, a[15:0] & CAMDS_SR_WMASK});
        check({28'h0, cpu_priority_o}, {29'h0, a[7:5]});
        wr(CAMDS_OFF_CONTROL, 32'hffff);
        rd(CAMDS_OFF_CONTROL, 32'h4);
        priority_raise_i <= 1'b1;
        @(posedge clock_i);
        priority_raise_i <= 1'b0;
        rd(CAMDS_OFF_CONTROL, 32'hc);
        check({28'h0, cpu_priority_o}, {28'h1, a[7:5]});
        wr(CAMDS_OFF_CONTROL, 32'h4);
        rd(CAMDS_OFF_CONTROL, 32'h4);
        for (int i = 0; i < 2; i++) begin
            a = $urandom;
            b = $urandom | 32'h8000;
            wr(CAMDS_OFF_PAGE, a);
            wr(CAMDS_OFF_EA, b);
            rd(CAMDS_OFF_MAPPED, {8'h0, ~i[0], a[7:0], b[14:0]});
            check({17'h0, data_word_addr_o}, {17'h0, b[15:1]});
            wr(CAMDS_OFF_CONTROL, 32'h0);
        end
        for (int i = 0; i < 25; i++) begin
            op = 4'(i % 5);
            a = i < 5 ? 32'h8000 : $urandom;
            b = i < 5 ? 32'h8000 : $urandom;
            wr(i < 20 ? wa(4'h2) : CAMDS_OFF_MEM_OPERAND, a);
            wr(wa(4'h3), b);
            wr(CAMDS_OFF_STATUS, 32'h0);
            wr(CAMDS_OFF_COMMAND, cmd(op, 4'h2, 4'h3, 4'h4, 3'h0, 5'h0)
                | {25'h0, i > 19, i > 19, 5'h0});
            p = alu(op, a[15:0], b[15:0]);
            rd(i < 20 ? wa(4'h4) : CAMDS_OFF_MEM_RESULT,
                {16'h0, p[15:0]});
            rd(CAMDS_OFF_STATUS, {16'h0, p[31:16]});
        end
        for (int i = 0; i < 12; i++) begin
            op = i < 6 ? CAMDS_OP_SHA : CAMDS_OP_SHL;
            a = $urandom;
            wr(wa(4'h2), a);
            wr(wa(4'h3), {16'h0, cnt[i % 6]});
            wr(CAMDS_OFF_COMMAND, cmd(op, 4'h2, 4'h3, 4'h4, 3'h0, 5'h0));
            rd(wa(4'h4), {16'h0, shf(op[0], a[15:0], cnt[i % 6])});
        end
        for (int i = 0; i < 12; i++) begin
            a = i < 6 ? 32'hffff : $urandom;
            b = i < 6 ? 32'h8001 : $urandom;
            l = 5'($urandom);
            wr(wa(4'h2), a);
            wr(wa(4'h3), b);
            wr(CAMDS_OFF_COMMAND, cmd(CAMDS_OP_MUL, 4'h2, 4'h3, 4'h5, 3'(i % 6), l));
            p = mul(3'(i % 6), a[15:0], b[15:0], l);
            rd(wa(4'h4), {16'h0, p[15:0]});
            rd(wa(4'h5), {16'h0, p[31:16]});
        end
        for (int i = 0; i < 4; i++) begin
            n = i == 3 ? 32'hfffe7960 : $urandom;
            d = i == 3 ? 32'd77 : $urandom | 32'h8001;
            if (i == 2)
                n[31:16] = 16'h1234;
            wr(wa(4'h6), n);
            wr(wa(4'h7), {16'h0, n[31:16]});
            wr(wa(4'h9), d);
            for (int s = 0; s < 18; s++) begin
                wr(CAMDS_OFF_COMMAND, cmd(CAMDS_OP_DIV, 4'h6, 4'h9, 4'h0, 3'(i), 5'h0));
                if (s == 4) begin
                    wr(CAMDS_OFF_COMMAND, cmd(4'h0, 4'h2, 4'h3, 4'h4, 3'h0, 5'h0));
                    bus(1'b0, CAMDS_OFF_STATUS, 32'h0, q);
                    check({31'h0, q[4]}, 32'h1);
                end
            end
            n = i[1] ? n : i[0] ? {{16{n[15]}}, n[15:0]} : {16'h0, n[15:0]};
            d = i[0] ? {{16{d[15]}}, d[15:0]} : {16'h0, d[15:0]};
            if (i[0]) begin
                q = $signed(n) / $signed(d);
                p = $signed(n) % $signed(d);
            end else begin
                q = n / d;
                p = n % d;
            end
            rd(wa(4'h0), {16'h0, q[15:0]});
            rd(wa(4'h1), {16'h0, p[15:0]});
        end
        complete_run();
    end
endmodule : camds_datapath_test
bind camds_datapath camds_datapath_props chk (.clock_i, .srst_i, .avs_req_i,
    .avs_rsp_o, .priority_raise_i, .cpu_priority_o, .program_window_hit_o,
    .program_addr_o, .data_word_addr_o);
